/* rtl/lsd_driver.sv */
// Overview of operation
// [R1] four commons and 38 segment outputs
// [R2] 1/4 duty default, 1/3 or 1/2 optional
// [R3] stored one lights segment, zero leaves dark
// [R4] segment area at one of two ranges
// [R5] lower range readable, upper range write-only
// [R6] segment memory not cleared by reset
// [R7] software clears segment area at start-up
// [R8] static pins output the common zero bit
// [R9] pin to memory bit mapping fixed at build
// [R10] drive-on bit resets zero, forces all off
// [R11] three timer mask bits, read/write, reset zero
// [R12] scan commons, each slot shows its bits
`timescale 1ns/10ps
module lsd_driver #(
  parameter int unsigned              SLOT_CYCLES = lsd_pkg::SLOT_CYCLES,
  parameter bit                       UPPER_RANGE = 1'b0,
  parameter int unsigned              COM_COUNT   = 4,
  parameter int unsigned              MAP_OFFSET  = 0,
  parameter logic [lsd_pkg::SEG_N-1:0] DC_PINS    = '0
) (
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // cpu data memory bus
  input  wire logic [lsd_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [lsd_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [lsd_pkg::DATA_W-1:0]    rdata_o,
  // control bits to the rest of the chip
  output logic                               display_drive_on_o,
  output logic                               tick_2hz_irq_allow_o,
  output logic                               tick_8hz_irq_allow_o,
  output logic                               tick_32hz_irq_allow_o,
  // panel electrodes, bit 0 is backplane_line_zero
  output logic      [lsd_pkg::COM_MAX-1:0]   backplane_o,
  output logic      [lsd_pkg::SEG_N-1:0]     glyph_drive_pin_o
);
  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic seg_hit(input logic [7:0] a);
    seg_hit = UPPER_RANGE ? in_range(a, lsd_pkg::HI_BASE, lsd_pkg::HI_LAST)
                          : in_range(a, lsd_pkg::LO_BASE, lsd_pkg::LO_LAST); // R4
  endfunction

  function automatic logic [lsd_pkg::WADDR_W-1:0] word_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - (UPPER_RANGE ? lsd_pkg::HI_BASE : lsd_pkg::LO_BASE);
    word_of = d[lsd_pkg::WADDR_W-1:0];
  endfunction

  // build-time pin map: segment s, common c -> word (s+offset) mod 48, bit c
  function automatic logic map_bit(input logic [lsd_pkg::FLAT_W-1:0] f,
                                   input int s, input int c);
    int w;
    w = (s + int'(MAP_OFFSET)) % lsd_pkg::MEM_WORDS; // R9
    map_bit = f[w*lsd_pkg::DATA_W + c];
  endfunction

  // ==========================================================
  // segment memory, deliberately without reset
  logic [lsd_pkg::FLAT_W-1:0] mem_flat;
  logic                       seg_we;

  assign seg_we = wr_i && seg_hit(addr_i);

  lsd_seg_ram u_ram (
    .clock_i (clock_i),
    .we_i    (seg_we),
    .waddr_i (word_of(addr_i)),
    .wdata_i (wdata_i),
    .mem_o   (mem_flat)
  ); // R6

  // ==========================================================
  // control register and read path
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [3:0] rdata_reg;
  logic [3:0] rdata_next;

  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (wr_i && addr_i == lsd_pkg::CTRL_ADDR) begin
      ctrl_next = wdata_i; // R10 R11
    end
    if (rd_i) begin
      if (addr_i == lsd_pkg::CTRL_ADDR) begin
        rdata_next = ctrl_reg; // R10 R11
      end else if (seg_hit(addr_i) && !UPPER_RANGE) begin
        rdata_next = mem_flat[word_of(addr_i)*lsd_pkg::DATA_W +: lsd_pkg::DATA_W]; // R5
      end else begin
        // upper range is write-only: reads give zero here
        rdata_next = 4'h0; // R5
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg  <= lsd_pkg::CTRL_RESET; // R10 R11
      rdata_reg <= 4'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o               = rdata_reg;
  assign display_drive_on_o    = ctrl_reg[lsd_pkg::DRIVE_BIT];
  assign tick_2hz_irq_allow_o  = ctrl_reg[lsd_pkg::T2_BIT];
  assign tick_8hz_irq_allow_o  = ctrl_reg[lsd_pkg::T8_BIT];
  assign tick_32hz_irq_allow_o = ctrl_reg[lsd_pkg::T32_BIT];

  // ==========================================================
  // slot divider and common scan
  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYCLES - 1);
  localparam logic [1:0]  COM_LAST  = 2'(COM_COUNT - 1);

  logic        drive;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick;
  logic [1:0]  slot_reg;
  logic [1:0]  slot_next;

  assign drive = ctrl_reg[lsd_pkg::DRIVE_BIT];
  assign tick  = drive && (cnt_reg == SLOT_LAST);

  always_comb begin
    cnt_next  = cnt_reg;
    slot_next = slot_reg;
    if (!drive) begin
      // restart from common zero so a fresh enable is aligned
      cnt_next  = 32'h0;
      slot_next = 2'h0;
    end else if (tick) begin
      cnt_next  = 32'h0;
      slot_next = (slot_reg == COM_LAST) ? 2'h0 : slot_reg + 2'h1; // R2 R12
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= 32'h0;
      slot_reg <= 2'h0;
    end else begin
      cnt_reg  <= cnt_next;
      slot_reg <= slot_next;
    end
  end

  // ==========================================================
  // electrode outputs
  logic [lsd_pkg::COM_MAX-1:0] bp_reg;
  logic [lsd_pkg::COM_MAX-1:0] bp_next;
  logic [lsd_pkg::SEG_N-1:0]   gl_reg;
  logic [lsd_pkg::SEG_N-1:0]   gl_next;

  always_comb begin
    bp_next = '0;
    gl_next = '0;
    if (drive) begin
      bp_next = 4'h1 << slot_reg; // R1 R12
      for (int s = 0; s < lsd_pkg::SEG_N; s++) begin
        if (DC_PINS[s]) begin
          gl_next[s] = map_bit(mem_flat, s, 0); // R8
        end else begin
          gl_next[s] = map_bit(mem_flat, s, int'(slot_reg)); // R3 R12
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bp_reg <= '0;
      gl_reg <= '0;
    end else begin
      bp_reg <= bp_next;
      gl_reg <= gl_next; // R10
    end
  end

  assign backplane_o       = bp_reg;
  assign glyph_drive_pin_o = gl_reg;

  // ==========================================================
  // checks
  logic [lsd_pkg::SEG_N-1:0] backplane_line_zero_vec;
  logic [lsd_pkg::SEG_N-1:0] slot_vec;

  always_comb begin
    for (int s = 0; s < lsd_pkg::SEG_N; s++) begin
      backplane_line_zero_vec[s] = map_bit(mem_flat, s, 0);
      slot_vec[s] = map_bit(mem_flat, s, int'(slot_reg));
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  drive_bit_write_a: assert property ( // R10
    wr_i && addr_i == lsd_pkg::CTRL_ADDR |=> display_drive_on_o == $past(wdata_i[3]))
    else $error("drive-on bit did not take written value");
  mask_bits_write_a: assert property ( // R11
    wr_i && addr_i == lsd_pkg::CTRL_ADDR |=> {tick_2hz_irq_allow_o, tick_8hz_irq_allow_o,
      tick_32hz_irq_allow_o} == $past(wdata_i[2:0]))
    else $error("mask bits did not take written value");
  off_forces_dark_a: assert property ( // R10
    !display_drive_on_o |=> glyph_drive_pin_o == '0 && backplane_o == '0)
    else $error("outputs active while drive is off");
  one_common_a: assert property ( // R2
    display_drive_on_o && $past(display_drive_on_o) |-> $onehot(backplane_o)
      && backplane_o < (5'h1 << COM_COUNT))
    else $error("common scan not one-hot within duty");
  slot_shows_bits_a: assert property ( // R3
    drive |=> (glyph_drive_pin_o & ~DC_PINS) == ($past(slot_vec) & ~DC_PINS))
    else $error("segment pins do not match slot memory bits");
  static_pins_a: assert property ( // R8
    drive |=> (glyph_drive_pin_o & DC_PINS) == ($past(backplane_line_zero_vec) & DC_PINS))
    else $error("static pins do not follow common zero bit");
  read_back_a: assert property ( // R5
    rd_i && seg_hit(addr_i) |=> rdata_o == (UPPER_RANGE ? 4'h0
      : $past(mem_flat[word_of(addr_i)*lsd_pkg::DATA_W +: lsd_pkg::DATA_W])))
    else $error("segment read returned wrong data");
  foreign_write_a: assert property ( // R4
    wr_i && !seg_hit(addr_i) |=> $stable(mem_flat))
    else $error("write outside active range changed segment memory");
  slot_advance_a: assert property ( // R12
    tick && display_drive_on_o ##1 display_drive_on_o |-> slot_reg ==
      ($past(slot_reg, 1) == COM_LAST ? 2'h0 : $past(slot_reg, 1) + 2'h1))
    else $error("common slot did not advance on divider tick");

  // ==========================================================
  // scan and bus checks
  // slot counters must sit still between ticks, else commons jitter

  slot_hold_a: assert property ( // R12
    drive && !tick
    |=> slot_reg == $past(slot_reg))
    else $error("common slot moved without divider tick");

  count_bound_a: assert property ( // R12
    cnt_reg <= SLOT_LAST
    )
    else $error("slot divider ran past its last count");

  slot_in_duty_a: assert property ( // R2
    slot_reg <= COM_LAST
    )
    else $error("common slot outside selected duty");

  off_restarts_a: assert property ( // R2
    !drive
    |=> slot_reg == 2'h0 && cnt_reg == 32'h0)
    else $error("scan not parked at common zero while off");

  bp_follows_slot_a: assert property ( // R12
    drive
    |=> backplane_o == (4'h1 << $past(slot_reg)))
    else $error("active common does not follow slot");

  // a write must land in the word it addressed, never a neighbour
  seg_write_a: assert property ( // R3
    wr_i && seg_hit(addr_i)
    |=> mem_flat[int'($past(word_of(addr_i)))*lsd_pkg::DATA_W +: lsd_pkg::DATA_W]
      == $past(wdata_i))
    else $error("segment write did not store data");

  ctrl_read_a: assert property ( // R10
    rd_i && addr_i == lsd_pkg::CTRL_ADDR
    |=> rdata_o == $past(ctrl_reg))
    else $error("control read returned wrong data");

  // read data must stand until the next read strobe
  read_hold_a: assert property ( // R5
    !rd_i
    |=> $stable(rdata_o))
    else $error("read data changed without a read");

  ctrl_hold_a: assert property ( // R11
    !(wr_i && addr_i == lsd_pkg::CTRL_ADDR)
    |=> $stable({display_drive_on_o, tick_2hz_irq_allow_o, tick_8hz_irq_allow_o,
      tick_32hz_irq_allow_o}))
    else $error("control bits changed without a write");

  // limitation: upper range and duty options are only checked by
  // these properties when the block is built with them selected
endmodule

/* rtl/lsd_pkg.sv */
package lsd_pkg;
  // ==========================================================
  // geometry
  localparam int          SEG_N     = 38;
  localparam int          COM_MAX   = 4;
  localparam int          DATA_W    = 4;
  localparam int          ADDR_W    = 8;
  localparam int          MEM_WORDS = 48;
  localparam int          WADDR_W   = 6;
  localparam int          FLAT_W    = MEM_WORDS * DATA_W;
  // ==========================================================
  // address map
  localparam logic [7:0]  LO_BASE   = 8'h40;
  localparam logic [7:0]  LO_LAST   = 8'h6F;
  localparam logic [7:0]  HI_BASE   = 8'hC0;
  localparam logic [7:0]  HI_LAST   = 8'hEF;
  localparam logic [7:0]  CTRL_ADDR = 8'h78;
  // ==========================================================
  // control register fields
  localparam logic [3:0]  CTRL_RESET = 4'h0;
  localparam int          DRIVE_BIT  = 3;
  localparam int          T2_BIT     = 2;
  localparam int          T8_BIT     = 1;
  localparam int          T32_BIT    = 0;
  // ==========================================================
  // timing: one common slot
  localparam int          CLK_MHZ      = 100;
  localparam int          SLOT_TIME_US = 1000;
  localparam int          SLOT_CYCLES  = SLOT_TIME_US * CLK_MHZ;
endpackage

/* rtl/lsd_seg_ram.sv */
`timescale 1ns/10ps
module lsd_seg_ram (
  // clock
  input  wire logic                              clock_i,
  // write port
  input  wire logic                              we_i,
  input  wire logic [lsd_pkg::WADDR_W-1:0]       waddr_i,
  input  wire logic [lsd_pkg::DATA_W-1:0]        wdata_i,
  // whole array, word 0 in the low bits
  output logic      [lsd_pkg::FLAT_W-1:0]        mem_o
);
  // ==========================================================
  // storage: no reset, contents stay unknown until written
  logic [lsd_pkg::DATA_W-1:0] mem [lsd_pkg::MEM_WORDS];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i; // R3
    end
  end

  always_comb begin
    for (int w = 0; w < lsd_pkg::MEM_WORDS; w++) begin
      mem_o[w*lsd_pkg::DATA_W +: lsd_pkg::DATA_W] = mem[w];
    end
  end
endmodule

/* verification/lsd_panel_model.sv */
`timescale 1ns/10ps
module lsd_panel_model (
  // clock
  input  wire logic                                            clock_i,
  // electrodes from the driver
  input  wire logic [lsd_pkg::COM_MAX-1:0]                     backplane_i,
  input  wire logic [lsd_pkg::SEG_N-1:0]                       glyph_i,
  // picture latched per common
  output logic      [lsd_pkg::COM_MAX-1:0][lsd_pkg::SEG_N-1:0] image_o,
  output logic                                                 overlap_o
);
  // ==========================================================
  // panel picture
  // sticky: two commons at once would smear the whole panel
  initial overlap_o = 1'b0;
  always @(posedge clock_i) begin
    overlap_o <= overlap_o | ($countones(backplane_i) > 1);
    for (int c = 0; c < lsd_pkg::COM_MAX; c++) begin
      if (backplane_i == (4'h1 << c)) begin
        image_o[c] <= glyph_i;
      end
    end
  end
endmodule

/* verification/lsd_driver_tb.sv */
`timescale 1ns/10ps
module lsd_driver_tb;
  // ==========================================================
  // signals
  logic             clock_i   = 1'b0;
  logic             rst_n_i   = 1'b0;
  logic [7:0]       addr_i    = 8'h00;
  logic [3:0]       wdata_i   = 4'h0;
  logic             wr_i      = 1'b0;
  logic             rd_i      = 1'b0;
  logic [3:0]       rdata_o;
  wire logic [3:0]  ctl;
  logic [3:0]       bp;
  logic [37:0]      gl;
  logic [3:0][37:0] img;
  logic             ovl;
  logic [3:0]       mem_exp [48];
  logic [3:0]       d;
  int               error_cnt = 0;
  int               compares  = 0;
  always #5 clock_i = ~clock_i;
  // short slot keeps the scan test fast; pin 0 is a static pin
  lsd_driver #(.SLOT_CYCLES(4), .UPPER_RANGE(1'b0), .COM_COUNT(4), .MAP_OFFSET(0),
    .DC_PINS(38'h1)) i_lsd_driver (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .display_drive_on_o(ctl[3]), .tick_2hz_irq_allow_o(ctl[2]),
    .tick_8hz_irq_allow_o(ctl[1]), .tick_32hz_irq_allow_o(ctl[0]),
    .backplane_o(bp), .glyph_drive_pin_o(gl));
  lsd_panel_model i_lsd_panel_model (.clock_i(clock_i), .backplane_i(bp), .glyph_i(gl),
    .image_o(img), .overlap_o(ovl));
  // ==========================================================
  // helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [3:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(posedge clock_i);
    #1 v = rdata_o;
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_bp(input logic [3:0] exp);
    int n;
    n = 0;
    while (bp !== exp && n < 40) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n >= 40) begin
      chk(bp, exp);
      finish_test();
    end
  endtask
  function automatic logic [37:0] exp_gl(input int c);
    logic [37:0] g;
    for (int s = 0; s < 38; s++) g[s] = mem_exp[s][(s == 0) ? 0 : c];
    return g;
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1 chk({ctl, bp, gl}, '0);
    rd(8'h78, d);
    chk(d, 4'h0);
    $display("t_reset done");
  endtask
  task automatic t_ctrl();
    logic [3:0] vals [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h7};
    foreach (vals[i]) begin
      wr(8'h78, vals[i]);
      @(posedge clock_i);
      #1 chk(ctl, vals[i]);
      rd(8'h78, d);
      chk(d, vals[i]);
    end
    chk({bp, gl}, '0);
    $display("t_ctrl done");
  endtask
  task automatic t_mem();
    for (int k = 0; k < 48; k++) begin
      mem_exp[k] = 4'((k * 5) + 3);
      wr(8'(8'h40 + k), mem_exp[k]);
    end
    wr(8'hC0, 4'hF);
    for (int k = 0; k < 48; k++) begin
      rd(8'(8'h40 + k), d);
      chk(d, mem_exp[k]);
    end
    rd(8'h3F, d);
    chk(d, 4'h0);
    rd(8'hC0, d);
    chk(d, 4'h0);
    $display("t_mem done");
  endtask
  task automatic t_scan();
    wr(8'h78, 4'h8);
    for (int c = 0; c < 5; c++) begin
      wait_bp(4'(1 << (c % 4)));
      chk(gl, exp_gl(c % 4));
    end
    for (int c = 0; c < 4; c++) chk(img[c], exp_gl(c));
    chk(img[3][0], mem_exp[0][0]);
    chk(ovl, 1'b0);
    wr(8'h78, 4'h0);
    @(posedge clock_i);
    #1 chk({bp, gl}, '0);
    $display("t_scan done");
  endtask
  task automatic t_keep();
    wr(8'h78, 4'hF);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(8'h45, d);
    chk(d, mem_exp[5]);
    chk(ctl, 4'h0);
    chk({bp, gl}, '0);
    $display("t_keep done");
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_mem();
    t_ctrl();
    t_scan();
    t_keep();
    finish_test();
  end
endmodule
